// file: rtl/rsd_pkg.sv
package rsd_pkg;
    // Register offsets in configuration space.
    localparam logic [11:0] RSD_OFF_ERR_SEL   = 12'h0B4;
    localparam logic [11:0] RSD_OFF_SLICE     = 12'h91C;
    localparam logic [11:0] RSD_OFF_ENABLES   = 12'h920;
    localparam logic [11:0] RSD_OFF_DECAY_CFG = 12'h928;
    localparam logic [11:0] RSD_OFF_CNT_LOW   = 12'h92C;
    localparam logic [11:0] RSD_OFF_CNT_HIGH  = 12'h930;
    // Field positions.
    localparam int RSD_SPARE_LSB   = 16;
    localparam int RSD_SPARE_W     = 13;
    localparam int RSD_NORM_LSB    = 0;
    localparam int RSD_NORM_W      = 16;
    localparam int RSD_MIRROR_BIT  = 0;
    localparam int RSD_PIN_BIT     = 17;
    localparam int RSD_NMI_BIT     = 16;
    localparam int RSD_SMI_BIT     = 15;
    localparam int RSD_UPPER_LSB   = 6;
    localparam int RSD_LOWER_LSB   = 0;
    localparam int RSD_SEL_W       = 6;
    localparam int RSD_LIMIT_LSB   = 12;
    localparam int RSD_LIMIT_W     = 2;
    // Counter shape.
    localparam int RSD_LOW_W       = 11;
    localparam int RSD_HIGH_W      = 42;
    localparam int RSD_CE_W        = 16;
    // Threshold code range and bit offset: code n selects bit n+11.
    localparam logic [5:0] RSD_SEL_MIN  = 6'h01;
    localparam logic [5:0] RSD_SEL_MAX  = 6'h29;
    // Reset values.
    localparam logic [31:0] RSD_SLICE_RST = 32'h0320_0C80;
    localparam logic [31:0] RSD_ZERO_RST  = 32'h0000_0000;
endpackage : rsd_pkg

// file: rtl/rsd_slice_arb.sv
`timescale 1ns/1ps
// Alternates normal and sparing windows, counting memory clocks.
module rsd_slice_arb
    import rsd_pkg::*;
(
    input  wire logic        sys_clk,    // Memory clock.
    input  wire logic        nrst,       // Async reset, active low.
    input  wire logic        spare_act,  // Sparing flow active.
    input  wire logic [15:0] norm_len,   // Normal window length.
    input  wire logic [12:0] spare_len,  // Sparing window length.
    output logic             in_spare    // High during sparing window.
);
    typedef enum logic [1:0] {RSD_IDLE, RSD_NORM, RSD_SPARE} rsd_win_t;
    typedef struct packed {
        rsd_win_t    win;
        logic [15:0] cnt;
    } rsd_arb_t;
    rsd_arb_t st_reg, st_next;

    // Window sequencing; a zero length still lasts one clock.
    always_comb begin
        st_next = st_reg;
        unique case (st_reg.win)
            RSD_IDLE: begin
                if (spare_act) begin
                    st_next.win = RSD_NORM;
                    st_next.cnt = 16'h0001;
                end
            end
            RSD_NORM: begin
                if (!spare_act) st_next.win = RSD_IDLE;
                else if (st_reg.cnt >= norm_len) begin
                    st_next.win = RSD_SPARE;
                    st_next.cnt = 16'h0001;
                end else st_next.cnt = st_reg.cnt + 16'h0001;
            end
            RSD_SPARE: begin
                if (!spare_act) st_next.win = RSD_IDLE;
                else if (st_reg.cnt >= {3'h0, spare_len}) begin
                    st_next.win = RSD_NORM;
                    st_next.cnt = 16'h0001;
                end else st_next.cnt = st_reg.cnt + 16'h0001;
            end
            default: st_next.win = RSD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) st_reg <= '{win: RSD_IDLE, cnt: 16'h0000};
        else st_reg <= st_next;
    end
    assign in_spare = (st_reg.win == RSD_SPARE);
endmodule : rsd_slice_arb

// file: rtl/rsd_decay_cnt.sv
`timescale 1ns/1ps
// Two-stage 53-bit decay counter with two-hot threshold match.
module rsd_decay_cnt
    import rsd_pkg::*;
(
    input  wire logic        sys_clk,                // Memory clock.
    input  wire logic        nrst,                   // Async reset, low.
    input  wire logic        enable,                 // Config nonzero.
    input  wire logic [5:0]  upper_threshold_select, // Upper code.
    input  wire logic [5:0]  lower_threshold_select, // Lower code.
    output logic [41:0]      upper_cnt,              // Upper 42-bit stage.
    output logic             strobe                  // Primary strobe.
);
    typedef struct packed {
        logic [10:0] low;
        logic [41:0] high;
        logic        stb;
    } rsd_dc_t;
    rsd_dc_t st_reg, st_next;
    logic [52:0] full;
    logic        hit_u, hit_l, ok_u, ok_l;

    assign full = {st_reg.high, st_reg.low};
    // Reserved codes select nothing, so a match can never fire.
    assign ok_u  = (upper_threshold_select >= RSD_SEL_MIN)
                   && (upper_threshold_select <= RSD_SEL_MAX);
    assign ok_l  = (lower_threshold_select >= RSD_SEL_MIN)
                   && (lower_threshold_select <= RSD_SEL_MAX);
    assign hit_u = ok_u && full[6'(upper_threshold_select + 6'd11)];
    assign hit_l = ok_l && full[6'(lower_threshold_select + 6'd11)];

    always_comb begin
        st_next     = st_reg;
        st_next.stb = 1'b0;
        if (!enable) begin
            st_next.low  = '0;
            st_next.high = '0;
        end else if (hit_u && hit_l) begin
            st_next.low  = '0;
            st_next.high = '0;
            st_next.stb  = 1'b1;
        end else begin
            st_next.low = st_reg.low + 11'h001;
            if (&st_reg.low) st_next.high = st_reg.high + 42'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) st_reg <= '0;
        else st_reg <= st_next;
    end
    assign upper_cnt = st_reg.high;
    assign strobe    = st_reg.stb;
endmodule : rsd_decay_cnt

// file: rtl/rsd_ras_ctrl.sv
`timescale 1ns/1ps
module rsd_ras_ctrl
    import rsd_pkg::*;
(
    input  wire logic        sys_clk,     // Memory clock, 40 MHz.
    input  wire logic        nrst,        // Async reset, active low.
    input  wire logic        cfg_wr,      // Config write strobe.
    input  wire logic        cfg_rd,      // Config read strobe.
    input  wire logic [11:0] cfg_addr,    // Config byte offset.
    input  wire logic [31:0] cfg_wdata,   // Config write data.
    output logic [31:0]      cfg_rdata,   // Config read data.
    output logic             cfg_rvalid,  // Read data valid pulse.
    input  wire logic        map_ready,   // Channel mapping configured.
    input  wire logic        spare_act,   // Sparing flow active.
    input  wire logic        sys_req,     // System request offered.
    output logic             sys_grant,   // System request taken.
    output logic             spare_win,   // Sparing copy window open.
    output logic             mirror_pol,  // Mirror error policy in use.
    input  wire logic        err_event,   // Error interrupt event.
    output logic             err_pin_n,   // First error pin, low active.
    output logic             nmi_out,     // Nonmaskable signal pulse.
    output logic             smi_out,     // Management signal pulse.
    input  wire logic        ce_load,     // Load error count.
    input  wire logic [15:0] ce_ld_val,   // Error count load value.
    output logic [15:0]      ce_count,    // Correctable error count.
    output logic             leak_pulse   // Leak pulse, one clock.
);
    typedef struct packed {
        logic [31:0] err_sel;
        logic [31:0] slice;
        logic [31:0] enables;
        logic [31:0] decay;
        logic [31:0] rdata;
        logic        rvalid;
        logic        grant;
        logic        spare;
        logic        mirror;
        logic        pin_n;
        logic        nmi;
        logic        smi;
        logic [1:0]  secondary_strobe_count;
        logic [15:0] ce;
        logic        leak;
    } rsd_st_t;
    rsd_st_t st_reg, st_next;
    logic        in_spare;
    logic [41:0] upper_cnt;
    logic        pstrobe;
    logic        decay_on;
    logic [1:0]  secondary_strobe_limit;
    logic        sec_hit;

    assign decay_on = |st_reg.decay;
    assign secondary_strobe_limit = st_reg.decay[RSD_LIMIT_LSB +: RSD_LIMIT_W];
    // limit decode, code 0 means four strobes. Comparing with >= means
    // a limit lowered in mid-count leaks at the next strobe, never wraps.
    assign sec_hit  = ({1'b0, st_reg.secondary_strobe_count} + 3'd1)
                      >= ((secondary_strobe_limit == 2'd0) ? 3'd4
                          : {1'b0, secondary_strobe_limit});

    rsd_slice_arb rsd_slice_arb_inst (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .spare_act (spare_act),
        .norm_len  (st_reg.slice[RSD_NORM_LSB +: RSD_NORM_W]),
        .spare_len (st_reg.slice[RSD_SPARE_LSB +: RSD_SPARE_W]),
        .in_spare  (in_spare)
    );

    rsd_decay_cnt rsd_decay_cnt_inst (
        .sys_clk                (sys_clk),
        .nrst                   (nrst),
        .enable                 (decay_on),
        .upper_threshold_select (st_reg.decay[RSD_UPPER_LSB +: RSD_SEL_W]),
        .lower_threshold_select (st_reg.decay[RSD_LOWER_LSB +: RSD_SEL_W]),
        .upper_cnt              (upper_cnt),
        .strobe                 (pstrobe)
    );

    // Register writes, read mux, request gating and error signalling.
    always_comb begin
        st_next        = st_reg;
        st_next.rvalid = cfg_rd;
        st_next.rdata  = 32'h0000_0000;
        st_next.leak   = 1'b0;
        st_next.nmi    = 1'b0;
        st_next.smi    = 1'b0;
        st_next.pin_n  = 1'b1;
        if (cfg_wr) begin
            unique case (cfg_addr)
                RSD_OFF_ERR_SEL:   st_next.err_sel = cfg_wdata & 32'h0003_8000;
                RSD_OFF_SLICE:     st_next.slice = cfg_wdata & 32'h1FFF_FFFF;
                RSD_OFF_ENABLES:   st_next.enables = cfg_wdata & 32'h0000_0001;
                RSD_OFF_DECAY_CFG: st_next.decay = cfg_wdata & 32'h0000_3FFF;
                default: ;
            endcase
        end
        if (cfg_rd) begin
            unique case (cfg_addr)
                RSD_OFF_ERR_SEL:   st_next.rdata = st_reg.err_sel;
                RSD_OFF_SLICE:     st_next.rdata = st_reg.slice;
                RSD_OFF_ENABLES:   st_next.rdata = st_reg.enables;
                RSD_OFF_DECAY_CFG: st_next.rdata = st_reg.decay;
                RSD_OFF_CNT_LOW:   st_next.rdata = upper_cnt[31:0];
                RSD_OFF_CNT_HIGH:  st_next.rdata = {22'h0, upper_cnt[41:32]};
                default:           st_next.rdata = 32'h0000_0000;
            endcase
        end
        st_next.spare = in_spare;
        // grant outside sparing window; an unheld request is dropped, not kept
        st_next.grant = sys_req && !in_spare;
        st_next.mirror = st_reg.enables[RSD_MIRROR_BIT] && map_ready;
        if (err_event) begin
            st_next.pin_n = !st_reg.err_sel[RSD_PIN_BIT];
            st_next.smi = st_reg.err_sel[RSD_SMI_BIT];
            st_next.nmi = st_reg.err_sel[RSD_NMI_BIT]
                          && !st_reg.err_sel[RSD_SMI_BIT];
        end
        if (!decay_on) st_next.secondary_strobe_count = 2'd0;
        else if (pstrobe) begin
            if (sec_hit) begin
                st_next.secondary_strobe_count = 2'd0;
                st_next.leak                   = 1'b1;
            end else begin
                st_next.secondary_strobe_count =
                    st_reg.secondary_strobe_count + 2'd1;
            end
        end
        if (ce_load) st_next.ce = ce_ld_val;
        else if (st_reg.leak && st_reg.ce != 16'h0000)
            st_next.ce = st_reg.ce - 16'h0001;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg       <= '0;
            st_reg.slice <= RSD_SLICE_RST;
            st_reg.pin_n <= 1'b1;
        end else st_reg <= st_next;
    end

    // Every output comes straight from the state flops.
    assign cfg_rdata  = st_reg.rdata;
    assign cfg_rvalid = st_reg.rvalid;
    assign sys_grant  = st_reg.grant;
    assign spare_win  = st_reg.spare;
    assign mirror_pol = st_reg.mirror;
    assign err_pin_n  = st_reg.pin_n;
    assign nmi_out    = st_reg.nmi;
    assign smi_out    = st_reg.smi;
    assign ce_count   = st_reg.ce;
    assign leak_pulse = st_reg.leak;

    property p_no_grant_spare;
        @(posedge sys_clk) disable iff (!nrst)
        in_spare |=> !sys_grant;
    endproperty
    a_no_grant_spare: assert property (p_no_grant_spare)
        else $error("grant during sparing window");

    property p_grant_norm;
        @(posedge sys_clk) disable iff (!nrst)
        (sys_req && !in_spare) |=> sys_grant;
    endproperty
    a_grant_norm: assert property (p_grant_norm)
        else $error("request not granted in normal window");

    property p_mirror;
        @(posedge sys_clk) disable iff (!nrst)
        !map_ready |=> !mirror_pol;
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror policy without mapping");

    property p_pin;
        @(posedge sys_clk) disable iff (!nrst)
        (err_event && st_reg.err_sel[RSD_PIN_BIT]) |=> !err_pin_n;
    endproperty
    a_pin: assert property (p_pin)
        else $error("error pin not asserted");

    property p_smi_only;
        @(posedge sys_clk) disable iff (!nrst)
        !(nmi_out && smi_out);
    endproperty
    a_smi_only: assert property (p_smi_only)
        else $error("both interrupts sent");

    property p_smi;
        @(posedge sys_clk) disable iff (!nrst)
        (err_event && st_reg.err_sel[RSD_SMI_BIT]) |=> smi_out;
    endproperty
    a_smi: assert property (p_smi)
        else $error("management interrupt missing");

    property p_no_leak;
        @(posedge sys_clk) disable iff (!nrst)
        (!decay_on && !$past(decay_on)) |-> !leak_pulse;
    endproperty
    a_no_leak: assert property (p_no_leak)
        else $error("leak while decay disabled");

    // leak decrements or holds at zero
    property p_ce_floor;
        @(posedge sys_clk) disable iff (!nrst)
        (leak_pulse && !ce_load) |=>
            (ce_count == (($past(ce_count) == 16'h0000) ? 16'h0000
                          : 16'($past(ce_count) - 16'h0001)));
    endproperty
    a_ce_floor: assert property (p_ce_floor)
        else $error("error count decrement wrong");

    property p_nmi;
        @(posedge sys_clk) disable iff (!nrst)
        (err_event && st_reg.err_sel[RSD_NMI_BIT]
         && !st_reg.err_sel[RSD_SMI_BIT]) |=> nmi_out;
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("nonmaskable signal missing");

    property p_quiet;
        @(posedge sys_clk) disable iff (!nrst)
        !err_event |=> (!nmi_out && !smi_out && err_pin_n);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("error signal without event");

    property p_leak_src;
        @(posedge sys_clk) disable iff (!nrst)
        leak_pulse |-> $past(pstrobe);
    endproperty
    a_leak_src: assert property (p_leak_src)
        else $error("leak without primary strobe");

    property p_leak_clr;
        @(posedge sys_clk) disable iff (!nrst)
        leak_pulse |-> (st_reg.secondary_strobe_count == 2'd0);
    endproperty
    a_leak_clr: assert property (p_leak_clr)
        else $error("secondary count kept after leak");

    property p_lim_one;
        @(posedge sys_clk) disable iff (!nrst)
        (pstrobe && decay_on && secondary_strobe_limit == 2'd1)
            |=> leak_pulse;
    endproperty
    a_lim_one: assert property (p_lim_one)
        else $error("limit one strobe gave no leak");

    property p_sec_clr;
        @(posedge sys_clk) disable iff (!nrst)
        !decay_on |=> (st_reg.secondary_strobe_count == 2'd0);
    endproperty
    a_sec_clr: assert property (p_sec_clr)
        else $error("secondary count runs while disabled");

    property p_strobe_one;
        @(posedge sys_clk) disable iff (!nrst)
        pstrobe |=> !pstrobe;
    endproperty
    a_strobe_one: assert property (p_strobe_one)
        else $error("primary strobe longer than one clock");

    property p_start_norm;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(spare_act) |=> !in_spare;
    endproperty
    a_start_norm: assert property (p_start_norm)
        else $error("sparing window opened first");

    property p_cnt_low;
        @(posedge sys_clk) disable iff (!nrst)
        (cfg_rd && cfg_addr == RSD_OFF_CNT_LOW)
            |=> (cfg_rdata == 32'($past(upper_cnt)));
    endproperty
    a_cnt_low: assert property (p_cnt_low)
        else $error("counter low readback wrong");
endmodule : rsd_ras_ctrl

// file: verif/rsd_ras_ctrl_tb.sv
`timescale 1ns/1ps
// Self-checking bench; it drives the config port and side inputs itself.
module rsd_ras_ctrl_tb;
    import rsd_pkg::*;
    logic        sys_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic        cfg_wr    = 1'b0;
    logic        cfg_rd    = 1'b0;
    logic [11:0] cfg_addr  = 12'h000;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic [31:0] cfg_rdata;
    logic        cfg_rvalid;
    logic        map_ready = 1'b0;
    logic        spare_act = 1'b0;
    logic        sys_req   = 1'b0;
    logic        sys_grant;
    logic        spare_win;
    logic        mirror_pol;
    logic        err_event = 1'b0;
    logic        err_pin_n;
    logic        nmi_out;
    logic        smi_out;
    logic        ce_load   = 1'b0;
    logic [15:0] ce_ld_val = 16'h0000;
    logic [15:0] ce_count;
    logic        leak_pulse;
    int          bad_count   = 0;
    int          check_count = 0;
    int          n;
    logic [31:0] v0;
    logic [31:0] v1;
    logic [11:0] addrs [5] = '{RSD_OFF_ERR_SEL, RSD_OFF_SLICE,
                               RSD_OFF_ENABLES, RSD_OFF_DECAY_CFG, 12'h924};
    logic [31:0] rstv  [5] = '{32'h0, RSD_SLICE_RST, 32'h0, 32'h0, 32'h0};
    logic [31:0] maskv [5] = '{32'h0003_8000, 32'h1FFF_FFFF, 32'h0000_0001,
                               32'h0000_3FFF, 32'h0};
    logic [1:0]  lims  [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int          strb  [4] = '{1, 2, 3, 4};
    logic [15:0] ces   [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000};

    rsd_ras_ctrl rsd_ras_ctrl_inst (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .cfg_wr     (cfg_wr),
        .cfg_rd     (cfg_rd),
        .cfg_addr   (cfg_addr),
        .cfg_wdata  (cfg_wdata),
        .cfg_rdata  (cfg_rdata),
        .cfg_rvalid (cfg_rvalid),
        .map_ready  (map_ready),
        .spare_act  (spare_act),
        .sys_req    (sys_req),
        .sys_grant  (sys_grant),
        .spare_win  (spare_win),
        .mirror_pol (mirror_pol),
        .err_event  (err_event),
        .err_pin_n  (err_pin_n),
        .nmi_out    (nmi_out),
        .smi_out    (smi_out),
        .ce_load    (ce_load),
        .ce_ld_val  (ce_ld_val),
        .ce_count   (ce_count),
        .leak_pulse (leak_pulse)
    );

    // Memory clock, 25 ns period.
    always #12.5 sys_clk = ~sys_clk;

    // Prints the verdict and stops the run.
    task automatic final_report;
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Four-state compare, so an unknown never counts as a match.
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // One-cycle write, launched on the falling edge; an idle cycle follows
    // so that back-to-back calls never drop and raise the strobe at once.
    task automatic cfg_write(input logic [11:0] a, input logic [31:0] d);
        cfg_wr    = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_wr = 1'b0;
        @(negedge sys_clk);
    endtask : cfg_write

    // Read data is due exactly one cycle after the read is taken.
    task automatic cfg_read(input logic [11:0] a, output logic [31:0] d);
        cfg_rd   = 1'b1;
        cfg_addr = a;
        @(negedge sys_clk);
        cfg_rd = 1'b0;
        d      = cfg_rdata;
        check("read valid", 32'h1, {31'h0, cfg_rvalid});
        @(negedge sys_clk);
        check("read valid drop", 32'h0, {31'h0, cfg_rvalid});
    endtask : cfg_read

    // Bounded wait for a leak pulse; running out ends the run.
    task automatic wait_leak(input int lim, output int cyc);
        cyc = 0;
        while (leak_pulse !== 1'b1) begin
            @(negedge sys_clk);
            cyc++;
            if (cyc > lim) begin
                bad_count++;
                $display("wrong value leak wait: expected pulse, seen none");
                final_report();
            end
        end
    endtask : wait_leak

    // Main sequence of scenarios.
    initial begin
        repeat (3) @(negedge sys_clk);
        check("pin in reset", 32'h1, {31'h0, err_pin_n});
        nrst = 1'b1;
        @(negedge sys_clk);
        // Reset values, write masks and an unmapped offset.
        for (int i = 0; i < 5; i++) begin
            cfg_read(addrs[i], v0);
            check("reset value", rstv[i], v0);
            cfg_write(addrs[i], 32'hFFFF_FFFF);
            cfg_read(addrs[i], v0);
            check("write mask", maskv[i], v0);
            cfg_write(addrs[i], 32'h0);
        end
        // Every combination of the three signalling selects.
        for (int i = 0; i < 8; i++) begin
            cfg_write(RSD_OFF_ERR_SEL, 32'(i) << 15);
            err_event = 1'b1;
            @(negedge sys_clk);
            err_event = 1'b0;
            check("smi", 32'(i % 2), {31'h0, smi_out});
            check("nmi", 32'(i % 4 == 2), {31'h0, nmi_out});
            check("pin", 32'(i < 4), {31'h0, err_pin_n});
            @(negedge sys_clk);
            check("idle", 32'h1, {29'h0, smi_out, nmi_out, err_pin_n});
        end
        // Mirror policy waits for the channel mapping.
        cfg_write(RSD_OFF_ENABLES, 32'h1);
        repeat (3) @(negedge sys_clk);
        check("mirror unmapped", 32'h0, {31'h0, mirror_pol});
        map_ready = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("mirror mapped", 32'h1, {31'h0, mirror_pol});
        // Windows of 4 normal and 3 sparing clocks with a held request.
        cfg_write(RSD_OFF_SLICE, 32'h0003_0004);
        sys_req   = 1'b1;
        spare_act = 1'b1;
        n = 0;
        while (spare_win !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check("normal first", 32'h1, 32'(n >= 4 && n <= 6));
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (spare_win === 1'b1 && n < 20) begin
                check("grant blocked", 32'h0, {31'h0, sys_grant});
                @(negedge sys_clk);
                n++;
            end
            check("spare length", 32'd3, 32'(n));
            n = 0;
            while (spare_win === 1'b0 && n < 20) begin
                check("grant open", 32'h1, {31'h0, sys_grant});
                @(negedge sys_clk);
                n++;
            end
            check("normal length", 32'd4, 32'(n));
        end
        spare_act = 1'b0;
        repeat (8) @(negedge sys_clk);
        check("idle grant", 32'h1, {30'h0, spare_win, sys_grant});
        // Every secondary limit, with the error count saturating at zero.
        ce_load   = 1'b1;
        ce_ld_val = 16'h0002;
        @(negedge sys_clk);
        ce_load = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg_write(RSD_OFF_DECAY_CFG, 32'h0);
            cfg_write(RSD_OFF_DECAY_CFG, {18'h0, lims[i], 12'h041});
            wait_leak(20000, n);
            v0 = 32'(n >= strb[i] * 4096 - 8 && n <= strb[i] * 4096 + 8);
            check("leak spacing", 32'h1, v0);
            @(negedge sys_clk);
            check("leak width", 32'h0, {31'h0, leak_pulse});
            check("error count", {16'h0, ces[i]}, {16'h0, ce_count});
        end
        // A reserved lower code, then a zero configuration, never leak.
        // The run is long enough to catch a reserved code read as bit 11.
        for (int j = 0; j < 2; j++) begin
            cfg_write(RSD_OFF_DECAY_CFG, 32'(1 - j) * 32'h0000_1040);
            n = 0;
            repeat (7000) begin
                @(negedge sys_clk);
                n += int'(leak_pulse === 1'b1);
            end
            check("no leak", 32'h0, 32'(n));
        end
        // Upper stage advances once per 2048 clocks and reads back.
        cfg_write(RSD_OFF_DECAY_CFG, 32'h0000_0A69);
        repeat (100) @(negedge sys_clk);
        cfg_read(RSD_OFF_CNT_LOW, v0);
        repeat (2046) @(negedge sys_clk);
        cfg_read(RSD_OFF_CNT_LOW, v1);
        check("stage step", 32'h1, v1 - v0);
        cfg_read(RSD_OFF_CNT_HIGH, v1);
        check("stage high", 32'h0, v1);
        final_report();
    end
endmodule : rsd_ras_ctrl_tb
